/* File: cfs_regs.vh */
// register offsets, reset values and timing counts of the converter fault supervisor
`ifndef CFS_REGS_VH
`define CFS_REGS_VH

// register byte addresses
`define CFS_ADDR_CTRL 8'h00
`define CFS_ADDR_OVERCURRENT_DELAY_COUNTER 8'h04
`define CFS_ADDR_CLKDIV 8'h08
`define CFS_ADDR_STATUS 8'h0C
`define CFS_ADDR_PHASES 8'h10
`define CFS_ADDR_CODE 8'h14

// control fields (write side strobes, read side mode)
`define CFS_CTRL_OFF_BIT 0
`define CFS_CTRL_ON_BIT 1

// status fields
`define CFS_ST_OC_BIT 0
`define CFS_ST_OL_BIT 1
`define CFS_ST_OV_BIT 2
`define CFS_ST_SENSE_BIT 3
`define CFS_ST_CHAIN_BIT 4
`define CFS_ST_ENLATCH_BIT 5
`define CFS_ST_OFFMODE_BIT 6
`define CFS_ST_SUPPLY_BIT 7
`define CFS_ST_POWER_GOOD_BIT 8
`define CFS_ST_RUN_BIT 9

// reset values
`define CFS_OVERCURRENT_DELAY_COUNTER_RST 8'h10
`define CFS_CLKDIV_RST 8'h0A
`define CFS_CODE_RST 7'h00

// timing counts, in phase clock pulses or phase-out cycles
`define CFS_CHAIN_WAIT 6'h1E
`define CFS_OPENLOOP_CYCLES 4'h8

`endif

/* File: cfs_fault_supervisor.v */
// fault supervision, soft start/stop sequencing and daisy-chain checking of the controller
// Operation
// (RULE1) count phase-out pulses while averaged current stays above the over-current threshold
// (RULE2) delay count reached: latch fault, clamp error amp, drop power good
// (RULE3) after an over-current fault, sink the ramp with the fault current
// (RULE4) over-current latch clears only on enable cycling or voltage-off command
// (RULE5) supply above upper lockout releases enable latch; below lower sets it
// (RULE6) voltage-off: soft stop, error amps active, ramp discharges at soft-stop current
// (RULE7) a non-off voltage code turns converter on and selects that voltage
// (RULE8) during soft start power good stays low until regulated and ramp past threshold
// (RULE9) power good low on any fault; high only fault-free and in regulation
// (RULE10) out of regulation drops power good only; code transitions are not counted
// (RULE11) error amp above open-loop limit for eight phase cycles latches a fault
// (RULE12) enable low sets fault latch; enable high allows a power-up ramp
// (RULE13) over-voltage on either output latches, clamps error amps, raises crowbar
// (RULE14) over-voltage latch holds power stage off until enable cycling or voltage-off
// (RULE15) low sensed output: test pulse sense lines; open line latches fault
// (RULE16) power-up: launch chain pulse, wait thirty clocks, retry once, then chain fault
// (RULE17) running: missing return relaunches pulse; second miss is a chain fault
// (RULE18) phase count taken from the return timing of the chain pulse
// (RULE19) phase clock runs at per-phase rate times phases; phase-out at per-phase rate
// (RULE20) error amp clamped until the ramp reaches its release level
// (RULE21) ramp low and cause gone resets the enable latch for a new soft start
// (RULE22) each phase chip passes the chain pulse on, one hop per phase
// (RULE23) comparators are synchronous inputs; faults ORed into one shutdown; only release events clear
`default_nettype none
`include "cfs_regs.vh"

module cfs_fault_supervisor #(
  parameter PHASE_W = 6,
  parameter [6:0] OFF_CODE = 7'h00
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clkEn,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [31:0] regRdData,
  input wire currentSenseAbove,
  input wire supplyAboveUpper,
  input wire supplyBelowLower,
  input wire enableHigh,
  input wire enableLow,
  input wire errAmpAboveLimit,
  input wire outOneOver,
  input wire outTwoOver,
  input wire outOneLow,
  input wire outTwoLow,
  input wire openLineTrip,
  input wire outOneInReg,
  input wire outTwoInReg,
  input wire codeTransition,
  input wire rampAboveRelease,
  input wire rampAbovePgood,
  input wire rampBelowLow,
  input wire voltageCodeStrobe,
  input wire [6:0] voltageCode,
  input wire chainPulseIn,
  output reg chainPulseOut,
  output reg phaseClockOut,
  output reg powerGood,
  output reg errAmpClamp,
  output reg crowbar,
  output reg rampCharge,
  output reg rampFaultSink,
  output reg rampSoftStop,
  output reg senseTestPulse,
  output reg shutdown,
  output reg [6:0] targetCode
);

  // chain checker states
  localparam [2:0] CH_IDLE = 3'b001;
  localparam [2:0] CH_DETECT = 3'b010;
  localparam [2:0] CH_RUN = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  reg [7:0] ocDelayLimit;
  reg [7:0] clkHalfDiv;
  wire wrCtrl = regWrEn && (regAddr == `CFS_ADDR_CTRL);
  wire swOff = wrCtrl && regWrData[`CFS_CTRL_OFF_BIT];
  wire swOn = wrCtrl && regWrData[`CFS_CTRL_ON_BIT] && !regWrData[`CFS_CTRL_OFF_BIT];

  // voltage code decode: off wins when both arrive together
  wire pinOff = voltageCodeStrobe && (voltageCode == OFF_CODE);
  wire pinOn = voltageCodeStrobe && (voltageCode != OFF_CODE);
  wire offCmd = pinOff || swOff;
  wire onCmd = (pinOn || swOn) && !offCmd;

  // software settings; a zero divider write is floored to one, which toggles the phase clock on every cycle as zero would
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ocDelayLimit <= `CFS_OVERCURRENT_DELAY_COUNTER_RST;
      clkHalfDiv <= `CFS_CLKDIV_RST;
    end else if (clkEn && regWrEn) begin
      if (regAddr == `CFS_ADDR_OVERCURRENT_DELAY_COUNTER)
        ocDelayLimit <= regWrData[7:0];
      if (regAddr == `CFS_ADDR_CLKDIV)
        clkHalfDiv <= (regWrData[7:0] == 8'h00) ? 8'h01 : regWrData[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase clock and phase-out pacing

  reg [7:0] divCnt;
  reg clockTick;
  reg [PHASE_W-1:0] phaseCount;
  reg [PHASE_W-1:0] slotCnt;
  reg launchTick;
  reg [2:0] chainState;

  // phase clock at per-phase rate times phases, one launch per phase slots [RULE19]
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      divCnt <= 8'h00;
      phaseClockOut <= 1'b0;
      clockTick <= 1'b0;
    end else if (clkEn) begin
      clockTick <= 1'b0;
      if (divCnt + 8'h01 >= clkHalfDiv) begin
        divCnt <= 8'h00;
        phaseClockOut <= !phaseClockOut;
        clockTick <= !phaseClockOut; // rising edge of the phase clock
      end else begin
        divCnt <= divCnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault sources

  reg supplyOk;
  reg offMode;
  reg enLatch;
  reg ocFault;
  reg olFault;
  reg ovFault;
  reg senseFault;
  reg chainFault;
  reg [7:0] ocCnt;
  reg [3:0] olCnt;
  reg inPrev;

  // enable cycling or voltage-off are the only releases of hard latches [RULE4] [RULE14]
  wire hardClear = enableLow || offCmd;
  wire anyHard = ocFault || olFault || ovFault || senseFault || chainFault;
  wire inEdge = chainPulseIn && !inPrev;

  // over-current delay runs on phase-out pulses, restarts when current drops [RULE1]
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ocCnt <= 8'h00;
      olCnt <= 4'h0;
    end else if (clkEn) begin
      if (!currentSenseAbove)
        ocCnt <= 8'h00;
      else if (launchTick && ocCnt != 8'hFF)
        ocCnt <= ocCnt + 8'h01; // [RULE1]
      if (!errAmpAboveLimit)
        olCnt <= 4'h0;
      else if (launchTick && olCnt != `CFS_OPENLOOP_CYCLES)
        olCnt <= olCnt + 4'h1;
    end
  end

  // hard latches: a set in the clearing cycle wins [RULE23]
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ocFault <= 1'b0;
      olFault <= 1'b0;
      ovFault <= 1'b0;
      senseFault <= 1'b0;
    end else if (clkEn) begin
      if (currentSenseAbove && ocCnt >= ocDelayLimit && ocDelayLimit != 8'h00)
        ocFault <= 1'b1; // [RULE2]
      else if (currentSenseAbove && ocDelayLimit == 8'h00)
        ocFault <= 1'b1; // zero delay trips at once
      else if (hardClear)
        ocFault <= 1'b0; // [RULE4]
      if (olCnt == `CFS_OPENLOOP_CYCLES)
        olFault <= 1'b1; // [RULE11]
      else if (hardClear)
        olFault <= 1'b0;
      if (outOneOver || outTwoOver)
        ovFault <= 1'b1; // [RULE13]
      else if (hardClear)
        ovFault <= 1'b0; // [RULE14]
      if (senseTestPulse && openLineTrip)
        senseFault <= 1'b1; // [RULE15]
      else if (hardClear)
        senseFault <= 1'b0;
    end
  end

  // supply lockout hysteresis and the enable-cleared latch [RULE5] [RULE12] [RULE21]
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      supplyOk <= 1'b0;
      offMode <= 1'b0;
      enLatch <= 1'b1;
      targetCode <= `CFS_CODE_RST;
      inPrev <= 1'b0;
    end else if (clkEn) begin
      inPrev <= chainPulseIn;
      if (supplyBelowLower)
        supplyOk <= 1'b0; // [RULE5]
      else if (supplyAboveUpper)
        supplyOk <= 1'b1;
      if (offCmd)
        offMode <= 1'b1; // [RULE6]
      else if (onCmd)
        offMode <= 1'b0; // [RULE7]
      if (pinOn)
        targetCode <= voltageCode; // [RULE7]
      if (enableLow || offCmd || supplyBelowLower || !supplyOk)
        enLatch <= 1'b1; // [RULE12]
      else if (rampBelowLow && enableHigh && !offMode && supplyOk)
        enLatch <= 1'b0; // [RULE21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // daisy-chain check and phase count

  reg [5:0] waitCnt;
  reg retried;
  reg returned;
  reg missedOnce;

  // detect: launch, time the return, retry once; run: watch every launch [RULE16]
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      chainState <= CH_IDLE;
      chainFault <= 1'b0;
      chainPulseOut <= 1'b0;
      launchTick <= 1'b0;
      phaseCount <= {{(PHASE_W-1){1'b0}}, 1'b1};
      slotCnt <= {PHASE_W{1'b0}};
      waitCnt <= 6'h00;
      retried <= 1'b0;
      returned <= 1'b0;
      missedOnce <= 1'b0;
    end else if (clkEn) begin
      launchTick <= 1'b0;
      if (clockTick)
        chainPulseOut <= 1'b0; // pulse stands one phase clock period
      // cleared by the release events; a set later in this process wins
      if (hardClear)
        chainFault <= 1'b0;
      case (chainState)
        CH_IDLE: begin
          if (!enLatch && !anyHard && clockTick) begin
            chainState <= CH_DETECT;
            chainPulseOut <= 1'b1;
            waitCnt <= 6'h00;
            retried <= 1'b0;
          end
        end
        CH_DETECT: begin
          if (inEdge && waitCnt != 6'h00) begin
            phaseCount <= waitCnt[PHASE_W-1:0]; // [RULE18]
            slotCnt <= {PHASE_W{1'b0}};
            returned <= 1'b1; // the measured pulse counts as the first return
            missedOnce <= 1'b0;
            chainState <= CH_RUN;
          end else if (clockTick) begin
            if (waitCnt == `CFS_CHAIN_WAIT) begin
              waitCnt <= 6'h00;
              if (retried) begin
                chainFault <= 1'b1; // [RULE16]
                chainState <= CH_IDLE;
              end else begin
                retried <= 1'b1;
                chainPulseOut <= 1'b1;
              end
            end else begin
              waitCnt <= waitCnt + 6'h01;
            end
          end
        end
        CH_RUN: begin
          if (inEdge)
            returned <= 1'b1;
          // judged the cycle after a launch: a return lands on the launch tick itself
          if (launchTick) begin
            returned <= 1'b0;
            if (returned || inEdge) begin
              missedOnce <= 1'b0;
            end else if (missedOnce) begin
              chainFault <= 1'b1; // [RULE17]
              chainState <= CH_IDLE;
            end else begin
              missedOnce <= 1'b1; // relaunch on the next pulse [RULE17]
            end
          end
          if (clockTick) begin
            if (slotCnt + {{(PHASE_W-1){1'b0}}, 1'b1} >= phaseCount) begin
              slotCnt <= {PHASE_W{1'b0}};
              chainPulseOut <= 1'b1; // phase-out at per-phase rate [RULE19]
              launchTick <= 1'b1;
            end else begin
              slotCnt <= slotCnt + {{(PHASE_W-1){1'b0}}, 1'b1};
            end
          end
        end
        default: chainState <= CH_IDLE;
      endcase
      if (enLatch || anyHard)
        chainState <= CH_IDLE; // every power-up checks the chain afresh
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing outputs

  // one shutdown from every hard latch, and from the enable latch outside off mode [RULE23]
  wire next_shutdown = anyHard || (enLatch && !offMode);
  // regulation ignores intended code moves [RULE10]
  wire inReg = (outOneInReg && outTwoInReg) || codeTransition;
  // power good: fault-free, ramp past threshold, in regulation [RULE8] [RULE9]
  wire next_powerGood = !anyHard && !enLatch && !offMode && rampAbovePgood && inReg &&
                        chainState == CH_RUN;
  // clamp on faults or until ramp release; soft stop keeps amps active [RULE6] [RULE20]
  wire next_errAmpClamp = anyHard || (enLatch && !offMode) || (!rampAboveRelease && !offMode);
  // ramp charges only after the chain passed [RULE12] [RULE16]
  wire next_rampCharge = !anyHard && !enLatch && !offMode && enableHigh &&
                         chainState == CH_RUN;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      powerGood <= 1'b0;
      errAmpClamp <= 1'b1;
      crowbar <= 1'b0;
      rampCharge <= 1'b0;
      rampFaultSink <= 1'b0;
      rampSoftStop <= 1'b0;
      senseTestPulse <= 1'b0;
      shutdown <= 1'b1;
    end else if (clkEn) begin
      shutdown <= next_shutdown; // [RULE23]
      powerGood <= next_powerGood; // [RULE9]
      errAmpClamp <= next_errAmpClamp; // [RULE2] [RULE13] [RULE15]
      crowbar <= anyHard; // [RULE13]
      rampCharge <= next_rampCharge;
      rampFaultSink <= anyHard; // [RULE3]
      rampSoftStop <= !anyHard && (offMode || enLatch); // [RULE6]
      senseTestPulse <= outOneLow || outTwoLow; // [RULE15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stand the cycle after the read strobe

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdData <= 32'h0000_0000;
      if (regRdEn) begin
        case (regAddr)
          `CFS_ADDR_CTRL: regRdData <= {31'h0000_0000, offMode};
          `CFS_ADDR_OVERCURRENT_DELAY_COUNTER: regRdData <= {24'h00_0000, ocDelayLimit};
          `CFS_ADDR_CLKDIV: regRdData <= {24'h00_0000, clkHalfDiv};
          `CFS_ADDR_STATUS: regRdData <= {22'h00_0000, chainState == CH_RUN, powerGood,
                                          supplyOk, offMode, enLatch, chainFault,
                                          senseFault, ovFault, olFault, ocFault};
          `CFS_ADDR_PHASES: regRdData <= {{(32-PHASE_W){1'b0}}, phaseCount};
          `CFS_ADDR_CODE: regRdData <= {25'h000_0000, targetCode};
          default: regRdData <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: cfs_chain_model.sv */
// behavioural daisy chain of phase chips on the far side of the supervisor
`default_nettype none
module cfs_chain_model #(
  parameter int PHASES = 3
) (
  input wire logic sys_clk,
  input wire logic phaseClockOut,
  input wire logic chainPulseOut,
  input wire logic broken,
  output logic chainPulseIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PHASES-1:0] hop = '0;
  logic lastClk = 1'b0;
  logic mid = 1'b0;
  ////////////////////////////////////////////////////////////////
  // sample mid period, pass on at the rising tick: one hop per chip
  always @(posedge sys_clk) begin
    lastClk <= phaseClockOut;
    if (phaseClockOut && !lastClk) hop <= {hop[PHASES-2:0], mid};
    if (!phaseClockOut && lastClk) mid <= chainPulseOut;
  end
  // a cut chain leaves the return line at its pull-down level
  assign chainPulseIn = broken ? 1'b0 : hop[PHASES-1];
endmodule
`default_nettype wire

/* File: cfs_fault_supervisor_sva.sv */
// concurrent checks on the fault supervisor ports
`default_nettype none
`include "cfs_regs.vh"
module cfs_fault_supervisor_sva #(
  parameter [6:0] OFF_CODE = 7'h00
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic enableLow,
  input wire logic outOneOver,
  input wire logic outOneLow,
  input wire logic outTwoInReg,
  input wire logic codeTransition,
  input wire logic rampAboveRelease,
  input wire logic rampAbovePgood,
  input wire logic voltageCodeStrobe,
  input wire logic [6:0] voltageCode,
  input wire logic powerGood,
  input wire logic errAmpClamp,
  input wire logic crowbar,
  input wire logic rampCharge,
  input wire logic rampSoftStop,
  input wire logic senseTestPulse,
  input wire logic shutdown,
  input wire logic [6:0] targetCode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] quiet;
  // off arrives on the code pins or as a control write
  wire offCmd = (voltageCodeStrobe && voltageCode == OFF_CODE) ||
                (regWrEn && regAddr == `CFS_ADDR_CTRL && regWrData[`CFS_CTRL_OFF_BIT]);
  ////////////////////////////////////////////////////////////////
  // cycles since the last release event; latches may only drop shortly after one
  always_ff @(posedge sys_clk) begin
    if (!rst_n || enableLow || offCmd) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  sequence s_held; shutdown [*3]; endsequence
  sequence s_on_cmd; voltageCodeStrobe && voltageCode != OFF_CODE; endsequence
  property p_pg_fault; s_held |-> !powerGood; endproperty
  a_pg_fault: assert property (p_pg_fault) else $error("power good with fault held");
  property p_block; s_held |-> !rampCharge; endproperty
  a_block: assert property (p_block) else $error("ramp charging with fault held");
  property p_ov; outOneOver |-> ##[1:4] crowbar && errAmpClamp; endproperty
  a_ov: assert property (p_ov) else $error("over-voltage not latched");
  property p_hold; crowbar && quiet > 3'h3 |=> crowbar; endproperty
  a_hold: assert property (p_hold) else $error("hard latch dropped on its own");
  property p_code; s_on_cmd |-> ##[1:3] targetCode == voltageCode; endproperty
  a_code: assert property (p_code) else $error("target code not taken");
  property p_off; offCmd |-> ##[1:4] rampSoftStop; endproperty
  a_off: assert property (p_off) else $error("no soft stop after off code");
  property p_pg_rise; $rose(powerGood) |-> $past(rampAbovePgood) && $past(outTwoInReg); endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("power good rose too early");
  property p_pg_drop; !outTwoInReg && !codeTransition |-> ##[1:4] !powerGood; endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("power good kept out of regulation");
  property p_clamp;
    !errAmpClamp && !rampSoftStop && !$past(rampSoftStop) |-> $past(rampAboveRelease);
  endproperty
  a_clamp: assert property (p_clamp) else $error("error amp released below level");
  property p_sense; outOneLow |-> ##[1:4] senseTestPulse; endproperty
  a_sense: assert property (p_sense) else $error("no sense test pulse");
endmodule
bind cfs_fault_supervisor cfs_fault_supervisor_sva #(.OFF_CODE(OFF_CODE)) cfs_sva_inst (.*);
`default_nettype wire

/* File: tb_top.sv */
// bench for the fault supervisor: supply, enable, faults, chain and codes
`default_nettype none
`include "cfs_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NPH = 3;
  localparam logic [6:0] OFFC = 7'h00;
  logic sys_clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, broken = 0, codeTransition = 0;
  logic currentSenseAbove = 0, errAmpAboveLimit = 0, outOneOver = 0, outTwoOver = 0;
  logic outOneLow = 0, openLineTrip = 0, outTwoInReg = 1, voltageCodeStrobe = 0;
  logic supplyAboveUpper = 0, supplyBelowLower = 1, enableHigh = 1, enableLow = 0;
  logic rampAboveRelease = 0, rampAbovePgood = 0, rampBelowLow = 1;
  logic clkEn = 1, outOneInReg = 1;
  logic [7:0] regAddr = 8'h00;
  logic [6:0] voltageCode = 7'h00, targetCode;
  logic [31:0] regWrData = 32'h0000_0000, regRdData, rdv, rnd, seed;
  logic chainPulseIn, chainPulseOut, phaseClockOut, powerGood, errAmpClamp, crowbar;
  logic rampCharge, rampFaultSink, rampSoftStop, senseTestPulse, shutdown;
  int errors = 0, check_count = 0, cycles = 0, n;
  longint t0;
  // unused comparator pin outTwoLow held at its quiet level
  cfs_fault_supervisor #(.OFF_CODE(OFFC)) cfs_fault_supervisor_inst (
    .outTwoLow(1'b0), .*);
  cfs_chain_model #(.PHASES(NPH)) cfs_chain_model_inst (.*);
  ////////////////////////////////////////////////////////////////
  initial forever #5 sys_clk = ~sys_clk;
  // ceiling well above the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    cyc(1);
    regWrEn <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRdEn <= 1'b1;
    cyc(1);
    regRdEn <= 1'b0;
    cyc(1);
    rdv = regRdData;
  endtask
  task automatic code(input logic [6:0] c);
    voltageCode <= c;
    voltageCodeStrobe <= 1'b1;
    cyc(1);
    voltageCodeStrobe <= 1'b0;
  endtask
  task automatic ramp_low();
    rampAboveRelease <= 1'b0;
    rampAbovePgood <= 1'b0;
    rampBelowLow <= 1'b1;
  endtask
  // ramp is let down only after the latch has had time to clamp
  task automatic en_cycle();
    enableLow <= 1'b1;
    enableHigh <= 1'b0;
    cyc(3);
    enableLow <= 1'b0;
    enableHigh <= 1'b1;
    ramp_low();
  endtask
  task automatic wait_sd();
    for (n = 0; n < 600 && shutdown !== 1'b1; n++) cyc(1);
  endtask
  task automatic power_up();
    for (n = 0; n < 2000 && rampCharge !== 1'b1; n++) cyc(1);
    chk(rampCharge, 1);
    rampBelowLow <= 1'b0;
    cyc(3);
    chk(errAmpClamp, 1);
    rampAboveRelease <= 1'b1;
    cyc(3);
    chk({errAmpClamp, powerGood}, 0);
    rampAbovePgood <= 1'b1;
    cyc(3);
    chk({powerGood, shutdown}, 2'b10);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h783f_15de;
    cyc(12);
    chk({powerGood, errAmpClamp, shutdown, crowbar, rampCharge}, 5'h0C);
    rst_n <= 1'b1;
    cyc(1);
    rd(`CFS_ADDR_OVERCURRENT_DELAY_COUNTER);
    chk(rdv, 32'h0000_0010);
    rd(8'h18);
    chk(rdv, 32'h0000_0000);
    wr(`CFS_ADDR_CLKDIV, 32'h0000_0002);
    cyc(40);
    chk({rampCharge, powerGood}, 0);
    supplyBelowLower <= 1'b0;
    supplyAboveUpper <= 1'b1;
    power_up();
    rd(`CFS_ADDR_PHASES);
    chk(rdv, NPH);
    @(posedge chainPulseOut);
    t0 = $time;
    @(posedge chainPulseOut);
    chk(32'(($time - t0) / 10), NPH * 4);
    cyc(1);
    // a planned code move is not out of regulation
    codeTransition <= 1'b1;
    outTwoInReg <= 1'b0;
    cyc(4);
    chk(powerGood, 1);
    codeTransition <= 1'b0;
    cyc(4);
    chk({powerGood, shutdown, errAmpClamp}, 0);
    outTwoInReg <= 1'b1;
    cyc(4);
    chk(powerGood, 1);
    outOneInReg <= 1'b0;
    cyc(4);
    chk(powerGood, 0);
    outOneInReg <= 1'b1;
    cyc(4);
    wr(`CFS_ADDR_OVERCURRENT_DELAY_COUNTER, 32'h0000_0003);
    // each comparator fault source except the chain, cleared alternately by enable and by off command
    for (int i = 0; i < 5; i++) begin
      {currentSenseAbove, errAmpAboveLimit, outOneOver, outTwoOver, openLineTrip} <= 5'h10 >> i;
      outOneLow <= (i == 4);
      wait_sd();
      {currentSenseAbove, errAmpAboveLimit, outOneOver, outTwoOver, openLineTrip} <= 5'h00;
      outOneLow <= 1'b0;
      cyc(20);
      rd(`CFS_ADDR_STATUS);
      chk(rdv[4:0], 5'h01 << (i - (i >= 3)));
      chk({shutdown, errAmpClamp, crowbar, rampFaultSink, powerGood}, 5'h1E);
      if (i % 2 == 0) en_cycle();
      else begin
        // off and on come by pin code once and by control write once
        if (i == 1) code(OFFC);
        else wr(`CFS_ADDR_CTRL, 32'h0000_0001);
        cyc(4);
        chk({rampSoftStop, errAmpClamp, crowbar}, 3'b100);
        rd(`CFS_ADDR_CTRL);
        chk(rdv, 32'h0000_0001);
        ramp_low();
        cyc(4);
        if (i == 3) wr(`CFS_ADDR_CTRL, 32'h0000_0002);
        else begin
          code(7'h2a);
          cyc(2);
          chk(targetCode, 7'h2a);
        end
      end
      power_up();
      rd(`CFS_ADDR_STATUS);
      chk(rdv[4:0], 5'h00);
    end
    supplyAboveUpper <= 1'b0;
    supplyBelowLower <= 1'b1;
    cyc(4);
    chk({powerGood, rampCharge, rampSoftStop}, 3'b001);
    ramp_low();
    supplyBelowLower <= 1'b0;
    supplyAboveUpper <= 1'b1;
    power_up();
    broken <= 1'b1;
    wait_sd();
    rd(`CFS_ADDR_STATUS);
    chk(rdv[`CFS_ST_CHAIN_BIT], 1);
    en_cycle();
    cyc(400);
    rd(`CFS_ADDR_STATUS);
    chk({rdv[`CFS_ST_CHAIN_BIT], rampCharge}, 2'b10);
    broken <= 1'b0;
    en_cycle();
    power_up();
    for (int k = 0; k < 16; k++) begin
      rnd = $random(seed);
      code(rnd[6:0] | 7'h01);
      cyc(3);
      chk(targetCode, rnd[6:0] | 7'h01);
      wr(`CFS_ADDR_OVERCURRENT_DELAY_COUNTER, rnd);
      rd(`CFS_ADDR_OVERCURRENT_DELAY_COUNTER);
      chk(rdv, {24'h00_0000, rnd[7:0]});
    end
    // clock enable low must freeze the phase clock, chain pulse, power good and shutdown
    clkEn <= 1'b0;
    cyc(1);
    rdv = {phaseClockOut, chainPulseOut, powerGood, shutdown};
    cyc(8);
    chk({phaseClockOut, chainPulseOut, powerGood, shutdown}, rdv);
    clkEn <= 1'b1;
    complete_run();
  end
endmodule
`default_nettype wire
